// file: dv/adcc_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"

module adcc_ctrl_tb;
    import adcc_pkg::*;

    // Short counts keep the run brief
    localparam int FC = 20;
    localparam int PW = 4;
    localparam int PD = 8;

    typedef struct {
        string       nm;
        logic [31:0] v;
        int          c;
    } adcc_note_t;

    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic [13:0] address  = 14'h0000;
    logic        read     = 1'b0;
    logic        write    = 1'b0;
    logic [3:0]  byteen   = 4'h0;
    logic [31:0] wdata    = 32'h00000000;
    logic [31:0] rdata;
    logic        waitreq, vref_en, core_pwr, dma_wr, irq, dma_start;
    logic [3:0]  chan, dma_chan;
    logic [9:0]  adc_data, lv;
    logic [11:0] dma_addr;
    logic [15:0] dma_data;
    logic [7:0]  base;
    logic [3:0]  ch;
    int          errors = 0;
    int          checks = 0;
    int          cyc    = 0;
    int          dcnt   = 0;
    int          seed   = 75604;
    int          last, r, s, k;
    adcc_note_t  rdq[$];
    adcc_note_t  dmq[$];
    adcc_note_t  mn;

    adcc_ctrl #(.FIRST_CYC(FC), .PWRUP_CYC(PW), .PERIOD_CYC(PD)) adcc_ctrl_i (
        .core_clk_i(core_clk), .srst_i(srst), .address_i(address),
        .read_i(read), .write_i(write), .byteenable_i(byteen),
        .writedata_i(wdata), .readdata_o(rdata), .waitrequest_o(waitreq),
        .dma_start_i(dma_start), .dma_chan_i(dma_chan),
        .adc_data_i(adc_data), .chan_o(chan), .vref_en_o(vref_en),
        .core_pwr_o(core_pwr), .dma_wr_o(dma_wr), .dma_addr_o(dma_addr),
        .dma_data_o(dma_data), .irq_o(irq));

    adcc_far adcc_far_i (
        .core_clk_i(core_clk), .adc_data_o(adc_data),
        .dma_start_o(dma_start), .dma_chan_o(dma_chan));

    always #50 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic summarize();
        $display("counts: checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task automatic bus(input logic w, input logic [11:0] idx,
                       input logic [7:0] d, input logic [3:0] be);
        int i;
        @(posedge core_clk);
        read    <= !w;
        write   <= w;
        address <= {idx, 2'b00};
        wdata   <= {24'h000000, d};
        byteen  <= be;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (waitreq === 1'b0)
                break;
        end
        last    = cyc;
        read    <= 1'b0;
        write   <= 1'b0;
        address <= ~address;
        wdata   <= ~wdata;
        if (i == 20) begin
            errors++;
            $display("wrong value waitrequest expected 0 seen 1");
            summarize();
        end
    endtask : bus

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'hF);
    endtask : wr

    task automatic rd(input string nm, input logic [11:0] idx,
                      input logic [7:0] e);
        rdq.push_back('{nm, {24'h000000, e}, 0});
        bus(1'b0, idx, 8'h00, 4'hF);
    endtask : rd

    task automatic edma(input string nm, input logic [11:0] a,
                        input logic [15:0] d, input int c);
        dmq.push_back('{nm, {4'h0, a, d}, c});
    endtask : edma

    task automatic wait_dma(input int n);
        int i;
        for (i = 0; i < 400 && dcnt < n; i++)
            @(posedge core_clk);
        if (dcnt < n) begin
            errors++;
            $display("wrong value dma count expected %0d seen %0d", n, dcnt);
            summarize();
        end
    endtask : wait_dma

    // ------------------------------------------------------------
    // Output watcher: oldest note against each result seen
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (read && waitreq === 1'b0) begin
            if (rdq.size() > 0)
                mn = rdq.pop_front();
            else
                mn = '{"read extra", 32'hXXXXXXXX, 0};
            cmp(mn.nm, mn.v, rdata);
        end
        if (dma_wr === 1'b1) begin
            dcnt <= dcnt + 1;
            if (dmq.size() > 0)
                mn = dmq.pop_front();
            else
                mn = '{"dma extra", 32'hXXXXXXXX, -1};
            cmp(mn.nm, mn.v, {4'h0, dma_addr, dma_data});
            cmp({mn.nm, " cycle"}, mn.c, cyc);
        end
    end

    initial begin
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        rd("ctrl reset", `ADCC_IDX_CTRL, 8'h00);
        rd("base reset", `ADCC_IDX_DMAB, 8'h00);
        rd("status reset", `ADCC_IDX_STAT, 8'h00);
        wr(12'h123, 8'h5A);
        rd("unmapped", 12'h123, 8'h00);
        $display("test reset done");

        r    = $random(seed);
        base = {r[7:1], 1'b0};
        wr(`ADCC_IDX_DMAB, base);
        rd("base", `ADCC_IDX_DMAB, base);
        bus(1'b1, `ADCC_IDX_DMAB, ~base, 4'h0);
        rd("base no strobe", `ADCC_IDX_DMAB, base);
        wr(`ADCC_IDX_MASK, 8'h01);
        rd("mask", `ADCC_IDX_MASK, 8'h01);
        $display("test registers done");

        // Single conversion from cold: power-up added
        r  = $random(seed);
        lv = r[9:0];
        ch = r[13:10];
        adcc_far_i.set_level(lv);
        wr(`ADCC_IDX_CTRL, {4'h0, ch});
        wr(`ADCC_IDX_CTRL, {4'h8, ch});
        s = last;
        edma("single", {base[7:1], ch, 1'b0}, {lv, 6'h00},
             s + PW + FC + 1);
        rd("go busy", `ADCC_IDX_CTRL, {4'h8, ch});
        wr(`ADCC_IDX_CTRL, {4'h0, ch});
        rd("go kept", `ADCC_IDX_CTRL, {4'h8, ch});
        wait_dma(1);
        rd("go done", `ADCC_IDX_CTRL, {4'h0, ch});
        rd("result high", `ADCC_IDX_RESH, lv[9:2]);
        rd("result low", `ADCC_IDX_RESL, {lv[1:0], 6'h00});
        cmp("irq single", 32'h1, {31'h0, irq});
        rd("status set", `ADCC_IDX_STAT, 8'h01);
        wr(`ADCC_IDX_STAT, 8'h01);
        repeat (2) @(posedge core_clk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        $display("test single done");

        // Continuous with reference on: no power-up
        r  = $random(seed);
        lv = r[9:0];
        ch = r[13:10];
        adcc_far_i.set_level(lv);
        wr(`ADCC_IDX_CTRL, {4'h3, ch});
        repeat (2) @(posedge core_clk);
        cmp("vref on", 32'h1, {31'h0, vref_en});
        wr(`ADCC_IDX_CTRL, {4'hB, ch});
        s = last;
        for (k = 0; k < 3; k++)
            edma("continuous_select", {base[7:1], ch, 1'b0}, {lv, 6'h00},
                 s + FC + 1 + k * PD);
        wait_dma(2);
        cmp("irq first", 32'h1, {31'h0, irq});
        rd("go cleared", `ADCC_IDX_CTRL, {4'h3, ch});
        wr(`ADCC_IDX_STAT, 8'h01);
        wait_dma(4);
        wr(`ADCC_IDX_CTRL, {4'h2, ch});
        rd("go still clear", `ADCC_IDX_CTRL, {4'h2, ch});
        repeat (3 * PD) @(posedge core_clk);
        cmp("irq later", 32'h0, {31'h0, irq});
        cmp("results", 32'h4, dcnt);
        $display("test continuous done");

        // DMA start, interrupt masked off
        wr(`ADCC_IDX_MASK, 8'h00);
        adcc_far_i.kick(4'h9);
        s = cyc;
        edma("dma start", {base[7:1], 4'h9, 1'b0}, {lv, 6'h00},
             s + FC + 1);
        repeat (2) @(posedge core_clk);
        cmp("chan", 32'h9, {28'h0, chan});
        cmp("powered", 32'h1, {31'h0, core_pwr});
        wait_dma(5);
        rd("status dma", `ADCC_IDX_STAT, 8'h01);
        cmp("irq masked", 32'h0, {31'h0, irq});
        $display("test dma start done");
        summarize();
    end
endmodule : adcc_ctrl_tb

`default_nettype wire

// file: dv/adcc_far.sv
// Far side model: converter core result level and DMA start requests
`timescale 1ns/100ps
`default_nettype none

module adcc_far (
    input  wire logic       core_clk_i,
    output var  logic [9:0] adc_data_o,
    output var  logic       dma_start_o,
    output var  logic [3:0] dma_chan_o
);
    initial begin
        adc_data_o  = 10'h000;
        dma_start_o = 1'b0;
        dma_chan_o  = 4'h0;
    end

    // ------------------------------------------------------------
    // Core level, held through a conversion so results are known
    // ------------------------------------------------------------
    task automatic set_level(input logic [9:0] v);
        @(posedge core_clk_i);
        adc_data_o <= v;
    endtask : set_level

    // ------------------------------------------------------------
    // DMA start pulse; channel turns to garbage once released
    // ------------------------------------------------------------
    task automatic kick(input logic [3:0] ch);
        @(posedge core_clk_i);
        dma_start_o <= 1'b1;
        dma_chan_o  <= ch;
        @(posedge core_clk_i);
        dma_start_o <= 1'b0;
        dma_chan_o  <= ~ch;
    endtask : kick
endmodule : adcc_far

`default_nettype wire

// file: src/adcc_ctrl.sv
// Converter control: control word, conversion sequencing, results, irq
`timescale 1ns/100ps
`default_nettype none
`include "adcc_regs.svh"

// Functional notes
// RULE1: Result address upper seven bits come from dma_result_base bits 7:1.
// RULE2: Lower five address bits are channel number then a zero.
// RULE3: Software writes zero to the reserved low bit of dma_result_base.
// RULE4: Software sets continuous, sets reference, then sets conversion_go.
// RULE5: First continuous result after 5129 cycles, plus 40 when powering up.
// RULE6: conversion_go clears at first result and stays clear afterward.
// RULE7: Only the first continuous result raises an interrupt request.
// RULE8: Later results every 256 cycles, split into high and low bytes.
// RULE9: Clearing continuous_select stops continuous conversion.
// RULE10: DMA controller may select channel and start conversion.
// RULE11: Control word layout go, reserved, vref, continuous_select, channel; reset zero.
// RULE12: conversion_go low means done; writing zero to it does nothing.
// RULE13: Reference enable bit drives the internal reference on or off.
// RULE14: Single mode converts once, clears go and raises one request.
// RULE15: Power-up delay only when converter was powered down at start.
module adcc_ctrl #(
    parameter int FIRST_CYC  = `ADCC_FIRST_CYC,
    parameter int PWRUP_CYC  = `ADCC_PWRUP_CYC,
    parameter int PERIOD_CYC = `ADCC_PERIOD_CYC,
    parameter int TW         = 13
)(
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic [13:0] address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output var  logic [31:0] readdata_o,
    output var  logic        waitrequest_o,
    input  wire logic        dma_start_i,
    input  wire logic [3:0]  dma_chan_i,
    input  wire logic [9:0]  adc_data_i,
    output var  logic [3:0]  chan_o,
    output var  logic        vref_en_o,
    output var  logic        core_pwr_o,
    output var  logic        dma_wr_o,
    output var  logic [11:0] dma_addr_o,
    output var  logic [15:0] dma_data_o,
    output var  logic        irq_o
);
    import adcc_pkg::*;

    adcc_state_t   state;
    adcc_state_t   next_state;
    logic          go;
    logic          vref;
    logic          continuous_select_sel;
    logic [3:0]    chan;
    logic [7:0]    dma_base;
    logic [7:0]    res_hi;
    logic [7:0]    res_lo;
    logic          stat_done;
    logic          mask_done;
    logic [9:0]    d_s1;
    logic [9:0]    d_s2;
    logic          start_d;
    logic [11:0]   idx;
    logic          req;
    logic          wr;
    logic          wr_ctrl;
    logic          go_start;
    logic          t_load;
    logic [TW-1:0] t_val;
    logic          t_done;
    logic          conv_end;
    logic          first_end;
    logic [31:0]   rdata;

    if (FIRST_CYC + PWRUP_CYC >= 2 ** TW || PERIOD_CYC < 2) begin : g_chk
        $error("adcc_ctrl: timer width cannot hold the counts");
    end

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, then the access completes
    // ------------------------------------------------------------
    assign idx = address_i[13:2];
    assign req = read_i | write_i;
    assign wr  = write_i & ~waitrequest_o & byteenable_i[0];
    assign wr_ctrl = wr && (idx == `ADCC_IDX_CTRL);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h0000_0000;
        end else if (req && waitrequest_o) begin
            waitrequest_o <= 1'b0;
            readdata_o    <= rdata;
        end else begin
            waitrequest_o <= 1'b1;
        end
    end

    // Unmapped indices read zero and ignore writes
    always_comb begin
        rdata = 32'h0000_0000;
        case (idx)
            `ADCC_IDX_CTRL: rdata[7:0] = {go, 1'b0, vref, continuous_select_sel, chan};
            `ADCC_IDX_DMAB: rdata[7:0] = dma_base;
            `ADCC_IDX_RESH: rdata[7:0] = res_hi;
            `ADCC_IDX_RESL: rdata[7:0] = res_lo;
            `ADCC_IDX_STAT: rdata[0]   = stat_done;
            `ADCC_IDX_MASK: rdata[0]   = mask_done;
            default:        rdata      = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Control word
    // ------------------------------------------------------------
    // Go is only honoured from idle; both sources share one path
    assign go_start = (state == ST_IDLE) &&
                      (dma_start_i ||
                       (wr_ctrl && writedata_i[`ADCC_GO_BIT])); // [RULE4]

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            {vref, continuous_select_sel, chan} <= 6'h00; // [RULE11]
        end else begin
            if (wr_ctrl) begin
                vref     <= writedata_i[`ADCC_VREF_BIT];
                continuous_select_sel <= writedata_i[`ADCC_CONTINUOUS_SELECT_BIT]; // [RULE9]
                chan     <= writedata_i[3:0];
            end
            if (dma_start_i && state == ST_IDLE) begin
                chan <= dma_chan_i; // [RULE10]
            end
        end
    end

    // Only hardware clears go; a written zero is dropped
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            go <= 1'b0;
        end else if (go_start) begin
            go <= 1'b1; // [RULE10]
        end else if (first_end) begin
            go <= 1'b0; // [RULE6] [RULE12] [RULE14]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dma_base <= `ADCC_DMAB_RST;
        end else if (wr && idx == `ADCC_IDX_DMAB) begin
            dma_base <= writedata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        t_load     = 1'b0;
        t_val      = '0;
        conv_end   = 1'b0;
        first_end  = 1'b0;
        case (state)
            ST_IDLE: begin
                if (go_start) begin
                    t_load = 1'b1;
                    if (core_pwr_o) begin
                        next_state = ST_CONV;
                        t_val = TW'(FIRST_CYC); // [RULE15]
                    end else begin
                        next_state = ST_PWRUP;
                        t_val = TW'(PWRUP_CYC); // [RULE15]
                    end
                end
            end
            ST_PWRUP: begin
                if (t_done) begin
                    next_state = ST_CONV;
                    t_load     = 1'b1;
                    t_val      = TW'(FIRST_CYC); // [RULE5]
                end
            end
            ST_CONV: begin
                if (t_done) begin
                    conv_end  = 1'b1;
                    first_end = 1'b1;
                    if (continuous_select_sel) begin
                        next_state = ST_CONTINUOUS_SELECT;
                        t_load     = 1'b1;
                        t_val      = TW'(PERIOD_CYC);
                    end else begin
                        next_state = ST_IDLE; // [RULE14]
                    end
                end
            end
            ST_CONTINUOUS_SELECT: begin
                if (!continuous_select_sel) begin
                    next_state = ST_IDLE; // [RULE9]
                    t_load     = 1'b1;
                end else if (t_done) begin
                    conv_end = 1'b1;
                    t_load   = 1'b1;
                    t_val    = TW'(PERIOD_CYC); // [RULE8]
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    adcc_timer #(
        .W (TW)
    ) u_timer (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .load_i     (t_load),
        .val_i      (t_val),
        .done_o     (t_done)
    );

    // ------------------------------------------------------------
    // Analog side
    // ------------------------------------------------------------
    // Core holds its result steady between edges of conversion end
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            d_s1 <= 10'h000;
            d_s2 <= 10'h000;
        end else begin
            d_s1 <= adc_data_i;
            d_s2 <= d_s1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            vref_en_o  <= 1'b0;
            core_pwr_o <= 1'b0;
            start_d    <= 1'b0;
            chan_o     <= 4'h0;
        end else begin
            vref_en_o  <= vref; // [RULE13]
            core_pwr_o <= vref || (next_state != ST_IDLE);
            start_d    <= go_start;
            // Channel is frozen once a conversion is under way
            if (state == ST_IDLE || start_d) begin
                chan_o <= chan;
            end
        end
    end

    // ------------------------------------------------------------
    // Results and DMA placement
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            res_hi     <= 8'h00;
            res_lo     <= 8'h00;
            dma_wr_o   <= 1'b0;
            dma_addr_o <= 12'h000;
            dma_data_o <= 16'h0000;
        end else begin
            dma_wr_o <= conv_end;
            if (conv_end) begin
                res_hi     <= d_s2[9:2]; // [RULE8]
                res_lo     <= {d_s2[1:0], 6'h00}; // [RULE8]
                dma_data_o <= {d_s2, 6'h00};
                // Reserved low bit of the base never reaches the bus
                // [RULE1] [RULE2] [RULE3]
                dma_addr_o <= {dma_base[7:1], chan_o, 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask, output
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            stat_done <= 1'b0;
            mask_done <= 1'b0;
            irq_o     <= 1'b0;
        end else begin
            // Set beats a write-one clear in the same cycle
            if (first_end) begin
                stat_done <= 1'b1; // [RULE7] [RULE14]
            end else if (wr && idx == `ADCC_IDX_STAT && writedata_i[0]) begin
                stat_done <= 1'b0;
            end
            if (wr && idx == `ADCC_IDX_MASK) begin
                mask_done <= writedata_i[0];
            end
            irq_o <= stat_done & mask_done;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [13:0] conv_cyc;
    logic [8:0]  upd_gap;
    logic        pwr_at_go;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            conv_cyc  <= 14'h0000;
            upd_gap   <= 9'h000;
            pwr_at_go <= 1'b0;
        end else begin
            conv_cyc <= go_start ? 14'h0001 : conv_cyc + 14'h0001;
            upd_gap  <= conv_end ? 9'h001 : upd_gap + 9'h001;
            if (go_start) begin
                pwr_at_go <= core_pwr_o;
            end
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_first_done;
        state == ST_CONV && t_done;
    endsequence

    sequence s_idle_done;
        !go && stat_done && state == ST_IDLE;
    endsequence

    a_addr_upper: assert property (dma_wr_o |-> // [RULE1]
        dma_addr_o[11:5] == $past(dma_base[7:1]))
        else $error("dma address upper bits wrong");
    a_addr_lower: assert property (dma_wr_o |-> // [RULE2]
        dma_addr_o[4:0] == {$past(chan_o), 1'b0})
        else $error("dma address lower bits wrong");
    a_first_time: assert property (s_first_done |-> // [RULE5]
        int'(conv_cyc) == FIRST_CYC + (pwr_at_go ? 0 : PWRUP_CYC))
        else $error("first conversion time wrong");
    a_go_held_low: assert property ((s_first_done ##0 continuous_select_sel) |=> // [RULE6]
        (!go && state == ST_CONTINUOUS_SELECT) [*2])
        else $error("go not cleared in continuous mode");
    a_irq_once: assert property ((state == ST_CONTINUOUS_SELECT && conv_end) |=> // [RULE7]
        !$rose(stat_done))
        else $error("request raised by later conversion");
    a_period: assert property ((state == ST_CONTINUOUS_SELECT && conv_end) |-> // [RULE8]
        int'(upd_gap) == PERIOD_CYC ##1 dma_wr_o)
        else $error("continuous period wrong");
    a_continuous_select_stop: assert property ((state == ST_CONTINUOUS_SELECT && !continuous_select_sel) |=> // [RULE9]
        state == ST_IDLE ##1 !dma_wr_o)
        else $error("continuous did not stop");
    a_dma_start: assert property ((dma_start_i && state == ST_IDLE) |=> // [RULE10]
        go && chan == $past(dma_chan_i) && state != ST_IDLE)
        else $error("dma start not taken");
    a_go_write0: assert property ((go && !first_end && wr_ctrl) |=> // [RULE12]
        go)
        else $error("written zero cleared go");
    a_vref: assert property (vref != $past(vref) |=> // [RULE13]
        vref_en_o == $past(vref))
        else $error("reference enable not followed");
    a_single: assert property ((s_first_done ##0 !continuous_select_sel) |=> // [RULE14]
        s_idle_done)
        else $error("single conversion end wrong");
    a_pwrup_skip: assert property ((go_start && core_pwr_o) |=> // [RULE15]
        state == ST_CONV)
        else $error("power-up delay applied while powered");

endmodule : adcc_ctrl

`default_nettype wire

// file: src/adcc_pkg.sv
// Types shared by the converter control block
package adcc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_PWRUP = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_CONTINUOUS_SELECT  = 4'b1000
    } adcc_state_t;

endpackage : adcc_pkg

// file: src/adcc_regs.svh
// Register indices, field positions, reset values and cycle counts
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ADCC_IDX_CTRL   12'hF70
`define ADCC_IDX_DMAB   12'hFBD
`define ADCC_IDX_RESH   12'hF71
`define ADCC_IDX_RESL   12'hF72
`define ADCC_IDX_STAT   12'hF73
`define ADCC_IDX_MASK   12'hF74

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define ADCC_GO_BIT     7
`define ADCC_VREF_BIT   5
`define ADCC_CONTINUOUS_SELECT_BIT   4
`define ADCC_CTRL_RST   8'h00
`define ADCC_DMAB_RST   8'h00

// ----------------------------------------------------------------
// Timing in system clock cycles
// ----------------------------------------------------------------
`define ADCC_FIRST_CYC  5129
`define ADCC_PWRUP_CYC  40
`define ADCC_PERIOD_CYC 256

`endif

// file: src/adcc_timer.sv
// Reloadable down counter that flags its last cycle
`timescale 1ns/100ps
`default_nettype none

module adcc_timer #(
    parameter int W = 13
)(
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] val_i,
    output var  logic         done_o
);

    logic [W-1:0] cnt;

    if (W < 2) begin : g_chk
        $error("adcc_timer: W too small");
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cnt <= '0;
        end else if (load_i) begin
            cnt <= val_i;
        end else if (cnt != '0) begin
            cnt <= cnt - W'(1);
        end
    end

    // Last cycle of a load of N lands N edges after the load
    always_comb begin
        done_o = (cnt == W'(1));
    end

endmodule : adcc_timer

`default_nettype wire
